// >>> hw/dsc_device.sv
// dac end: serial shift logic on the link clock, control pins and dac register on clk
`timescale 1ns/1ps
`include "dsc_regs.svh"

module dsc_device
    import dsc_pkg::*;
#(
    parameter int FRAME_W = `DSC_FRAME_W,
    parameter int DATA_W  = `DSC_DATA_W
)(
    input  wire logic              clk,
    input  wire logic              rst_n,
    dsc_link_if.device             link,
    input  wire logic              overTemp,
    input  wire logic              shortCircuit,
    input  wire logic              brownout,
    output logic [DATA_W-1:0]      dacCode,
    output logic                   outEnable,
    output logic                   outUpdate,
    output logic [1:0]             clearSel
);

    localparam int CW = $clog2(FRAME_W);

    // ****************************************
    // link clock domain
    // ****************************************
    logic [FRAME_W-1:0] shift_reg;
    logic [CW-1:0]      txCnt_reg;
    logic               serialOut_reg;
    logic [FRAME_W-1:0] rbWord_reg;
    logic               rbArm_reg;
    logic [CW-1:0]      txIdx;

    // input bits enter on falling sclk while the frame is open
    // host guarantees the bit is settled at that edge
    always_ff @(negedge link.sclk or negedge rst_n) begin
        if (!rst_n) begin
            shift_reg <= '0;
        end else if (!link.frameSelN) begin
            shift_reg <= {shift_reg[FRAME_W-2:0], link.serialIn};
        end
    end

    assign txIdx = CW'(FRAME_W - 1) - txCnt_reg;

    // output bit moves on rising sclk, read by the far side at the next fall
    // the frame's own select clears the count, since sclk stops between frames
    always_ff @(posedge link.sclk or posedge link.frameSelN) begin
        if (link.frameSelN) begin
            txCnt_reg     <= '0;
            serialOut_reg <= 1'b0;
        end else begin
            txCnt_reg     <= txCnt_reg + CW'(1);
            serialOut_reg <= rbArm_reg ? rbWord_reg[txIdx] : shift_reg[FRAME_W-1];
        end
    end

    assign link.serialOut = serialOut_reg;

    // ****************************************
    // pin synchronisers
    // ****************************************
    // order: frame, load, clear, reset, temp, short, brownout
    localparam logic [6:0] SYNC_IDLE = 7'h78;
    logic [6:0] meta_reg;
    logic [6:0] sync_reg;
    logic [6:0] prev_reg;

    // every asynchronous pin passes two flops before use
    // idle value is high for the strobes, matching the internal pull-ups
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_reg <= SYNC_IDLE;
            sync_reg <= SYNC_IDLE;
            prev_reg <= SYNC_IDLE;
        end else begin
            meta_reg <= {link.frameSelN, link.loadStrobeN, link.clearN, link.hwResetN,
                         overTemp, shortCircuit, brownout};
            sync_reg <= meta_reg;
            prev_reg <= sync_reg;
        end
    end

    logic frameS;
    logic loadS;
    logic resetS;
    logic faultS;
    logic commitEv;
    logic loadFallEv;
    logic clearFallEv;

    assign frameS      = sync_reg[6];
    assign loadS       = sync_reg[5];
    assign resetS      = sync_reg[3];
    assign faultS      = |sync_reg[2:0];
    assign commitEv    = sync_reg[6] & ~prev_reg[6];  // rising frame select
    assign loadFallEv  = ~sync_reg[5] & prev_reg[5];
    assign clearFallEv = ~sync_reg[4] & prev_reg[4];

    // ****************************************
    // frame decode
    // ****************************************
    logic [FRAME_W-1:0] word;
    dsc_cmd_t           cmd;
    logic [DATA_W-1:0]  data;
    logic               wrInput;
    logic               wrUpd;
    logic               wrCtrl;
    logic               swReset;

    // shift_reg is still once the frame closed, so sampling it here is safe
    assign word    = shift_reg;
    assign cmd     = dsc_cmd_t'(word[`DSC_CMD_MSB:`DSC_CMD_LSB]);
    assign data    = word[DATA_W-1:0];
    assign wrInput = commitEv && (cmd == DSC_CMD_WR_INPUT);
    assign wrUpd   = commitEv && (cmd == DSC_CMD_WR_UPD);
    assign wrCtrl  = commitEv && (cmd == DSC_CMD_WR_CTRL);
    assign swReset = commitEv && (cmd == DSC_CMD_SW_RESET);

    // preset code picked by the clear select field
    function automatic logic [DATA_W-1:0] presetCode(input logic [1:0] sel);
        logic [DATA_W-1:0] code;
        code = DATA_W'(`DSC_CODE_ZERO);
        if (sel == DSC_CLR_MID) begin
            code = DATA_W'(`DSC_CODE_MID);
        end else if (sel == DSC_CLR_FULL) begin
            code = DATA_W'(`DSC_CODE_FULL);
        end
        return code;
    endfunction : presetCode

    // ****************************************
    // registers on clk
    // ****************************************
    logic [DATA_W-1:0] input_reg;
    logic [DATA_W-1:0] dacCode_reg;
    logic [1:0]        clearSel_reg;
    logic              outEnable_reg;
    logic              alertHold_reg;
    logic              alertOe_reg;
    logic              outUpdate_reg;
    logic              defaultState;

    // hardware reset pin held low, or a software reset, means power-on state
    assign defaultState = ~resetS | swReset;

    // input register takes input writes and write-with-update, not control writes
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            input_reg <= DATA_W'(`DSC_RST_CODE);
        end else if (defaultState) begin
            input_reg <= DATA_W'(`DSC_RST_CODE);
        end else if (wrInput || wrUpd) begin
            input_reg <= data;
        end
    end

    // dac register; priority: reset, clear, write-with-load, strobe fall
    // a strobe fall in the commit cycle transfers the new word, not the old one
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            dacCode_reg   <= DATA_W'(`DSC_RST_CODE);
            outUpdate_reg <= 1'b0;
        end else if (defaultState) begin
            dacCode_reg   <= DATA_W'(`DSC_RST_CODE);
            outUpdate_reg <= 1'b0;
        end else if (clearFallEv) begin
            dacCode_reg   <= presetCode(clearSel_reg);
            outUpdate_reg <= 1'b1;
        end else if (wrUpd || (wrInput && !loadS) || (wrInput && loadFallEv)) begin
            dacCode_reg   <= data;
            outUpdate_reg <= 1'b1;
        end else if (loadFallEv) begin
            dacCode_reg   <= input_reg;
            outUpdate_reg <= 1'b1;
        end else begin
            outUpdate_reg <= 1'b0; // strobe high during write: held off
        end
    end

    // control register: clear preset choice and output enable
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            clearSel_reg  <= `DSC_RST_CLRSEL;
            outEnable_reg <= 1'b0;
        end else if (defaultState) begin
            clearSel_reg  <= `DSC_RST_CLRSEL;
            outEnable_reg <= 1'b0; // clamped, buffer down
        end else if (wrCtrl) begin
            clearSel_reg  <= data[`DSC_CLRSEL_MSB:`DSC_CLRSEL_LSB];
            outEnable_reg <= 1'b1;
        end
    end

    // ****************************************
    // alert and readback
    // ****************************************
    // held from any reset until a control write; faults pull low as a level
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            alertHold_reg <= 1'b1;
            alertOe_reg   <= 1'b1;
        end else begin
            if (defaultState) begin
                alertHold_reg <= 1'b1;
            end else if (wrCtrl) begin
                alertHold_reg <= 1'b0;
            end
            alertOe_reg <= faultS | defaultState | (alertHold_reg & ~wrCtrl);
        end
    end

    // readback word is set at commit while sclk is idle; the next frame reads it
    // after the frame gap, which outlasts the select synchroniser
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rbArm_reg  <= 1'b0;
            rbWord_reg <= '0;
        end else if (commitEv) begin
            rbArm_reg  <= (cmd == DSC_CMD_READBACK);
            rbWord_reg <= {word[FRAME_W-1:DATA_W], input_reg};
        end else if (!frameS) begin
            rbArm_reg  <= rbArm_reg;
        end
    end

    assign link.alertOe = alertOe_reg;
    assign dacCode      = dacCode_reg;
    assign outEnable    = outEnable_reg;
    assign outUpdate    = outUpdate_reg;
    assign clearSel     = clearSel_reg;

endmodule : dsc_device

// >>> inc/dsc_regs.svh
// timing counts and field layout of the serial dac control link
`ifndef DSC_REGS_SVH
`define DSC_REGS_SVH

// ****************************************
// frame layout
// ****************************************
`define DSC_FRAME_W      24
`define DSC_DATA_W       16
`define DSC_CMD_MSB      23
`define DSC_CMD_LSB      20
`define DSC_CLRSEL_MSB   1
`define DSC_CLRSEL_LSB   0

// ****************************************
// preset codes and reset values
// ****************************************
`define DSC_CODE_ZERO    16'h0000
`define DSC_CODE_MID     16'h8000
`define DSC_CODE_FULL    16'hffff
`define DSC_RST_CODE     16'h0000
`define DSC_RST_CLRSEL   2'h0

// ****************************************
// link timing
// ****************************************
`define DSC_CLK_NS        5
`define DSC_SETUP_NS      15
`define DSC_TRAIL_NS      10
`define DSC_GAP_NS        50
`define DSC_CYC_MIN(ns)   (((ns) + `DSC_CLK_NS - 1) / `DSC_CLK_NS)
`define DSC_HALF_CYC      4

`endif

// >>> inc/dsc_pkg.sv
// types shared by both ends of the serial dac control link
package dsc_pkg;

    // frame commands in bits 23:20
    typedef enum logic [3:0] {
        DSC_CMD_NOP      = 4'h0,
        DSC_CMD_WR_INPUT = 4'h1,
        DSC_CMD_WR_UPD   = 4'h3,
        DSC_CMD_WR_CTRL  = 4'h4,
        DSC_CMD_READBACK = 4'ha,
        DSC_CMD_SW_RESET = 4'hf
    } dsc_cmd_t;

    // preset selected for the clear pin
    typedef enum logic [1:0] {
        DSC_CLR_ZERO = 2'h0,
        DSC_CLR_MID  = 2'h1,
        DSC_CLR_FULL = 2'h2
    } dsc_clrsel_t;

    // host link sequencer states
    typedef enum logic [4:0] {
        DSC_ST_IDLE  = 5'b00001,
        DSC_ST_LEAD  = 5'b00010,
        DSC_ST_SHIFT = 5'b00100,
        DSC_ST_TRAIL = 5'b01000,
        DSC_ST_GAP   = 5'b10000
    } dsc_state_t;

endpackage : dsc_pkg

// >>> inc/dsc_link_if.sv
// pin-level link between the host serial port and the dac control logic
`timescale 1ns/1ps

interface dsc_link_if;
    logic sclk;
    logic frameSelN;
    logic serialIn;
    logic serialOut;
    logic loadStrobeN;
    logic clearN;
    logic hwResetN;
    logic alertOe;
    logic alertN;

    // open-drain alert with pull-up: low only while the device drives it
    assign alertN = alertOe ? 1'b0 : 1'b1;

    modport device (
        input  sclk,
        input  frameSelN,
        input  serialIn,
        output serialOut,
        input  loadStrobeN,
        input  clearN,
        input  hwResetN,
        output alertOe
    );

    modport host (
        output sclk,
        output frameSelN,
        output serialIn,
        input  serialOut,
        output loadStrobeN,
        output clearN,
        output hwResetN,
        input  alertN
    );
endinterface : dsc_link_if

// >>> hw/dsc_host.sv
// host end: divides clk into sclk and runs one framed transfer per request
`timescale 1ns/1ps
`include "dsc_regs.svh"

module dsc_host
    import dsc_pkg::*;
#(
    parameter int FRAME_W  = `DSC_FRAME_W,
    parameter int HALF_CYC = `DSC_HALF_CYC
)(
    input  wire logic               clk,
    input  wire logic               rst_n,
    dsc_link_if.host                link,
    input  wire logic               start,
    input  wire logic [FRAME_W-1:0] txWord,
    input  wire logic               loadLevelN,
    input  wire logic               clearLevelN,
    input  wire logic               resetLevelN,
    output logic                    busy,
    output logic                    done,
    output logic [FRAME_W-1:0]      rxWord,
    output logic                    alertActive
);

    localparam int LEAD_CYC  = `DSC_CYC_MIN(`DSC_SETUP_NS);
    localparam int TRAIL_CYC = `DSC_CYC_MIN(`DSC_TRAIL_NS);
    localparam int GAP_CYC   = `DSC_CYC_MIN(`DSC_GAP_NS);
    localparam int CW        = $clog2(FRAME_W + 1);

    dsc_state_t         state_reg;
    logic [7:0]         phase_reg;
    logic [CW-1:0]      bitCnt_reg;
    logic [FRAME_W-1:0] tx_reg;
    logic [FRAME_W-1:0] rx_reg;
    logic               sclk_reg;
    logic               frameSelN_reg;
    logic               serialIn_reg;
    logic               done_reg;
    logic               busy_reg;
    logic               alertAct_reg;
    logic [1:0]         soSync_reg;
    logic [1:0]         alSync_reg;
    logic [2:0]         pins_reg;

    // ****************************************
    // input synchronisers
    // ****************************************
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            soSync_reg <= 2'h0;
            alSync_reg <= 2'h3;
            alertAct_reg <= 1'b0;
        end else begin
            soSync_reg <= {soSync_reg[0], link.serialOut};
            alSync_reg <= {alSync_reg[0], link.alertN};
            alertAct_reg <= ~alSync_reg[1]; // status leaves on a flop, one cycle later
        end
    end

    // strobe pins registered so they leave on flops
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pins_reg <= 3'h7;
        end else begin
            pins_reg <= {loadLevelN, clearLevelN, resetLevelN};
        end
    end

    // ****************************************
    // transfer sequencer
    // ****************************************
    // sclk idles low; data changes on the rise so it is settled at the fall
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg     <= DSC_ST_IDLE;
            phase_reg     <= 8'h00;
            bitCnt_reg    <= '0;
            tx_reg        <= '0;
            rx_reg        <= '0;
            sclk_reg      <= 1'b0;
            frameSelN_reg <= 1'b1;
            serialIn_reg  <= 1'b0;
            done_reg      <= 1'b0;
            busy_reg      <= 1'b0;
        end else begin
            done_reg <= 1'b0;
            case (state_reg)
                DSC_ST_IDLE: begin
                    if (start) begin
                        tx_reg        <= txWord;
                        frameSelN_reg <= 1'b0; // frame opens
                        phase_reg     <= 8'h00;
                        state_reg     <= DSC_ST_LEAD;
                        busy_reg      <= 1'b1;
                    end
                end
                DSC_ST_LEAD: begin
                    phase_reg <= phase_reg + 8'h01;
                    if (phase_reg == 8'(LEAD_CYC - 1)) begin
                        phase_reg  <= 8'h00;
                        bitCnt_reg <= '0;
                        state_reg  <= DSC_ST_SHIFT;
                    end
                end
                DSC_ST_SHIFT: begin
                    phase_reg <= phase_reg + 8'h01;
                    if (phase_reg == 8'h00) begin
                        sclk_reg     <= 1'b1;
                        serialIn_reg <= tx_reg[FRAME_W-1]; // stable before fall
                        tx_reg       <= {tx_reg[FRAME_W-2:0], 1'b0};
                    end else if (phase_reg == 8'(HALF_CYC)) begin
                        sclk_reg <= 1'b0;
                        rx_reg   <= {rx_reg[FRAME_W-2:0], soSync_reg[1]};
                        bitCnt_reg <= bitCnt_reg + CW'(1);
                    end else if (phase_reg == 8'(2 * HALF_CYC - 1)) begin
                        phase_reg <= 8'h00;
                        if (bitCnt_reg == CW'(FRAME_W)) begin
                            state_reg <= DSC_ST_TRAIL;
                        end
                    end
                end
                DSC_ST_TRAIL: begin
                    phase_reg <= phase_reg + 8'h01;
                    if (phase_reg == 8'(TRAIL_CYC - 1)) begin
                        frameSelN_reg <= 1'b1; // commit edge
                        phase_reg     <= 8'h00;
                        done_reg      <= 1'b1;
                        state_reg     <= DSC_ST_GAP;
                    end
                end
                DSC_ST_GAP: begin
                    phase_reg <= phase_reg + 8'h01;
                    if (phase_reg == 8'(GAP_CYC - 1)) begin
                        state_reg <= DSC_ST_IDLE;
                        busy_reg  <= 1'b0; // gap over, next request may follow
                    end
                end
                default: begin
                    state_reg <= DSC_ST_IDLE;
                end
            endcase
        end
    end

    assign link.sclk        = sclk_reg;
    assign link.frameSelN   = frameSelN_reg;
    assign link.serialIn    = serialIn_reg;
    assign link.loadStrobeN = pins_reg[2];
    assign link.clearN      = pins_reg[1];
    assign link.hwResetN    = pins_reg[0];
    assign busy             = busy_reg;
    assign done             = done_reg;
    assign rxWord           = rx_reg;
    assign alertActive      = alertAct_reg;

endmodule : dsc_host

// >>> test/dsc_monitor.sv
// concurrent checks on the link pins and the dac outputs
`timescale 1ns/1ps

module dsc_monitor #(
    parameter int DATA_W = 16
)(
    input  wire logic              clk,
    input  wire logic              rst_n,
    input  wire logic              sclk,
    input  wire logic              frameSelN,
    input  wire logic              serialOut,
    input  wire logic              loadStrobeN,
    input  wire logic              clearN,
    input  wire logic              hwResetN,
    input  wire logic              alertOe,
    input  wire logic              overTemp,
    input  wire logic              shortCircuit,
    input  wire logic              brownout,
    input  wire logic [DATA_W-1:0] dacCode,
    input  wire logic              outUpdate,
    input  wire logic              outEnable
);
    // ****************************************
    // properties, one clock domain
    // ****************************************
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    // any fault source, as one level
    logic anyFault;
    assign anyFault = overTemp | shortCircuit | brownout;

    property p_fault_alert;
        anyFault [*4] |-> alertOe;
    endproperty
    a_fault_alert: assert property (p_fault_alert) else $error("alert not driven on fault");

    property p_reset_state;
        (!hwResetN) [*4] |-> alertOe && !outEnable && dacCode == '0;
    endproperty
    a_reset_state: assert property (p_reset_state) else $error("reset pin state wrong");

    // release only shortly after a frame commit or a fault going away
    property p_alert_release;
        $fell(alertOe) |-> !$past(frameSelN, 8) || $past(anyFault, 4);
    endproperty
    a_alert_release: assert property (p_alert_release) else $error("alert released without cause");

    property p_clear;
        $fell(clearN) |-> ##[2:6] outUpdate;
    endproperty
    a_clear: assert property (p_clear) else $error("clear edge gave no update");

    // mid-frame, with load and clear held high, nothing may reach the dac register
    property p_frame_quiet;
        (!frameSelN && loadStrobeN && clearN) [*8] |-> !outUpdate;
    endproperty
    a_frame_quiet: assert property (p_frame_quiet) else $error("update inside a frame");

    // latency margin: events older than 7 cycles must have settled
    property p_quiet_hold;
        (frameSelN && loadStrobeN && clearN && hwResetN) [*8] |-> $stable(dacCode) && !outUpdate;
    endproperty
    a_quiet_hold: assert property (p_quiet_hold) else $error("dac changed with no cause");

    property p_upd_pulse;
        outUpdate |=> !outUpdate;
    endproperty
    a_upd_pulse: assert property (p_upd_pulse) else $error("update pulse too long");

    property p_sout_edge;
        !frameSelN && !sclk && !$past(sclk) && !$past(sclk, 2) |-> $stable(serialOut);
    endproperty
    a_sout_edge: assert property (p_sout_edge) else $error("serial out moved in low phase");
endmodule : dsc_monitor

// >>> test/tb_dac_serial_control_pins.sv
// self-checking bench: host and device ends joined over the link interface
`timescale 1ns/1ps
`include "dsc_regs.svh"

module tb_dac_serial_control_pins import dsc_pkg::*; ;
    logic        clk         = 1'b0;
    logic        rst_n       = 1'b0;
    logic        start       = 1'b0;
    logic [23:0] txWord      = 24'h000000;
    logic        loadLevelN  = 1'b1;
    logic        clearLevelN = 1'b1;
    logic        resetLevelN = 1'b1;
    logic [2:0]  faultSrc    = 3'h0;
    logic        busy;
    logic        done;
    logic        alertActive;
    logic [23:0] rxWord;
    logic [15:0] dacCode;
    logic        outEnable;
    logic        outUpdate;
    logic [1:0]  clearSel;
    logic [15:0] expDac[$];
    logic [24:0] expRx[$];
    logic [24:0] rxNote;
    logic [23:0] rxModel     = 24'h000000;
    logic [15:0] inReg       = 16'h0000;
    logic [15:0] d;
    logic [15:0] preset[3]   = '{`DSC_CODE_ZERO, `DSC_CODE_MID, `DSC_CODE_FULL};
    int          seed        = 32'hb321eaa5;
    int          n_errors    = 0;
    int          checked     = 0;

    // ****************************************
    // clock, ends and checker
    // ****************************************
    always #2.5 clk = ~clk;

    dsc_link_if link ();

    dsc_host dsc_host_inst (.clk(clk), .rst_n(rst_n), .link(link), .start(start), .txWord(txWord),
        .loadLevelN(loadLevelN), .clearLevelN(clearLevelN), .resetLevelN(resetLevelN), .busy(busy),
        .done(done), .rxWord(rxWord), .alertActive(alertActive));

    dsc_device dsc_device_inst (.clk(clk), .rst_n(rst_n), .link(link), .overTemp(faultSrc[0]),
        .shortCircuit(faultSrc[1]), .brownout(faultSrc[2]), .dacCode(dacCode), .outEnable(outEnable),
        .outUpdate(outUpdate), .clearSel(clearSel));

    dsc_monitor #(.DATA_W(`DSC_DATA_W)) dsc_monitor_inst (.clk(clk), .rst_n(rst_n), .sclk(link.sclk),
        .frameSelN(link.frameSelN), .serialOut(link.serialOut), .loadStrobeN(link.loadStrobeN),
        .clearN(link.clearN), .hwResetN(link.hwResetN), .alertOe(link.alertOe), .overTemp(faultSrc[0]),
        .shortCircuit(faultSrc[1]), .brownout(faultSrc[2]), .dacCode(dacCode), .outUpdate(outUpdate),
        .outEnable(outEnable));

    // ****************************************
    // tasks
    // ****************************************
    task automatic chk(input logic [23:0] got, input logic [23:0] exp);
        checked++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic end_sim;
        $display("checks=%0d mismatches=%0d", checked, n_errors);
        if (n_errors == 0 && checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : end_sim

    // one frame; the readback model follows the previous frame's word
    task automatic send(input dsc_cmd_t cmd, input logic [15:0] data, input logic keepRx);
        int i;
        @(negedge clk);
        txWord = {cmd, 4'h0, data};
        start  = 1'b1;
        expRx.push_back({keepRx, rxModel});
        @(negedge clk);
        start = 1'b0;
        for (i = 0; i < 2000 && busy !== 1'b0; i++)
            @(negedge clk);
        chk(24'(busy), 24'h0);
        rxModel = (cmd == DSC_CMD_READBACK) ? {txWord[23:16], inReg} : txWord;
        if (cmd == DSC_CMD_WR_INPUT || cmd == DSC_CMD_WR_UPD)
            inReg = data;
    endtask : send

    task automatic idle(input int n);
        repeat (n) @(negedge clk);
    endtask : idle

    // ****************************************
    // scoreboard
    // ****************************************
    // an update with no note pending compares against unknown, so it fails
    always @(posedge clk) begin
        if (outUpdate === 1'b1)
            chk(24'(dacCode), (expDac.size() != 0) ? 24'(expDac.pop_front()) : 24'hxxxxxx);
        if (done === 1'b1 && expRx.size() != 0) begin
            rxNote = expRx.pop_front();
            if (rxNote[24])
                chk(rxWord, rxNote[23:0]);
        end
    end

    // hang guard, far above the expected run of about 17 us
    initial begin
        #200000;
        n_errors++;
        end_sim();
    end

    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        idle(12);
        rst_n = 1'b1;
        idle(4);
        chk(24'({link.alertN, outEnable, dacCode}), 24'h0);
        send(DSC_CMD_WR_CTRL, 16'h0001, 1'b1);
        chk(24'({link.alertN, outEnable, clearSel}), 24'hc | 24'(DSC_CLR_MID));
        $display("test reset and control done");
        // deferred update waits for the strobe edge
        d = 16'($random(seed));
        send(DSC_CMD_WR_INPUT, d, 1'b1);
        chk(24'(dacCode), 24'h0);
        expDac.push_back(d);
        loadLevelN = 1'b0;
        idle(10);
        for (int k = 0; k < 3; k++) begin
            d = 16'($random(seed));
            expDac.push_back(d);
            send(DSC_CMD_WR_INPUT, d, 1'b1);
        end
        loadLevelN = 1'b1;
        d = 16'($random(seed));
        expDac.push_back(d);
        send(DSC_CMD_WR_UPD, d, 1'b1);
        $display("test load strobe done");
        // every clear preset in turn
        for (int s = 0; s < 3; s++) begin
            send(DSC_CMD_WR_CTRL, 16'(s), 1'b1);
            expDac.push_back(preset[s]);
            clearLevelN = 1'b0;
            idle(10);
            clearLevelN = 1'b1;
            idle(10);
        end
        $display("test clear done");
        d = 16'($random(seed));
        send(DSC_CMD_WR_INPUT, d, 1'b1);
        send(DSC_CMD_READBACK, 16'h0000, 1'b1);
        send(DSC_CMD_NOP, 16'h0000, 1'b1);
        $display("test readback done");
        for (int f = 0; f < 3; f++) begin
            faultSrc = 3'h1 << f;
            idle(8);
            chk(24'({link.alertN, alertActive}), 24'h1);
            faultSrc = 3'h0;
            idle(8);
            chk(24'({link.alertN, alertActive}), 24'h2);
        end
        $display("test faults done");
        // hardware reset pin; shift contents afterwards are not modelled
        resetLevelN = 1'b0;
        idle(10);
        chk(24'({link.alertN, outEnable, dacCode}), 24'h0);
        resetLevelN = 1'b1;
        inReg = 16'h0000;
        idle(6);
        send(DSC_CMD_WR_CTRL, 16'h0002, 1'b0);
        chk(24'(link.alertN), 24'h1);
        send(DSC_CMD_SW_RESET, 16'h0000, 1'b1);
        idle(4);
        chk(24'({link.alertN, outEnable, dacCode}), 24'h0);
        send(DSC_CMD_WR_CTRL, 16'h0000, 1'b0);
        $display("test resets done");
        idle(20);
        chk(24'(expDac.size()), 24'h0);
        end_sim();
    end
endmodule : tb_dac_serial_control_pins
